// file: hw/ptd_pkg.sv
// package for the test, diagnostic and led register bank
package ptd_pkg;
   // register addresses
   localparam logic [8:0] A_TBT   = 9'h01a;
   localparam logic [8:0] A_BC1   = 9'h01b;
   localparam logic [8:0] A_BC2   = 9'h01c;
   localparam logic [8:0] A_CDC   = 9'h01e;
   localparam logic [8:0] A_RST   = 9'h01f;
   localparam logic [8:0] A_MLED  = 9'h025;
   localparam logic [8:0] A_COMP  = 9'h027;
   localparam logic [8:0] A_D101  = 9'h101;
   localparam logic [8:0] A_D10A  = 9'h10a;
   localparam logic [8:0] A_D123  = 9'h123;
   localparam logic [8:0] A_D130  = 9'h130;
   localparam logic [8:0] A_CDS   = 9'h170;
   localparam logic [8:0] A_BSTAT = 9'h001;
   localparam logic [8:0] A_PSTS  = 9'h010;
   // writable masks (reserved bits excluded)
   localparam logic [15:0] M_TBT  = 16'h3e81;
   localparam logic [15:0] M_BC2  = 16'h07ff;
   localparam logic [15:0] M_MLED = 16'h0279;
   localparam logic [15:0] M_COMP = 16'h000f;
   localparam logic [15:0] M_D101 = 16'hff9f;
   localparam logic [15:0] M_D123 = 16'h7fff;
   localparam logic [15:0] M_D130 = 16'h7fff;
   localparam logic [15:0] M_CDS  = 16'h7770;
   // reset values
   localparam logic [7:0]  R_GAP  = 8'h7d;
   localparam logic [15:0] R_BC2  = 16'h05ee;
   localparam logic [15:0] R_MLED = 16'h0041;
   localparam logic [15:0] R_D101 = 16'h2082;
   localparam logic [15:0] R_D10A = 16'h2040;
   localparam logic [15:0] R_D123 = 16'h051c;
   localparam logic [15:0] R_D130 = 16'h4f28;
   localparam logic [15:0] R_CDS  = 16'h0c12;
   // field positions
   localparam int B_THR = 13;
   localparam int B_SQH = 12;
   localparam int B_SQL = 9;
   localparam int B_NLP = 7;
   localparam int B_POL = 4;
   localparam int B_JAB = 0;
   localparam int B_FRZ = 15;
   localparam int B_START = 15;
   localparam int B_RESCAL = 14;
   localparam int B_HRST = 15;
   localparam int B_DRST = 14;
   localparam int B_SWAP = 9;
   localparam int B_SRCH = 6;
   localparam int B_SRCL = 3;
   localparam int B_ROUTE = 0;
   // led source codes
   localparam logic [3:0] L_LOST = 4'hd;
   localparam logic [3:0] L_PRBS = 4'he;
   localparam logic [7:0] CNT_MAX = 8'hff;
   // length of the internal restart pulse, cycles
   localparam logic [3:0] RESTART_CYC = 4'h8;

   // management access
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [8:0]  addr;
      logic [15:0] wdata;
   } ptd_mgmt_t;

   // led status inputs from the datapath
   typedef struct packed {
      logic link;
      logic rxtx_act;
      logic tx_act;
      logic rx_act;
      logic col;
      logic spd100;
      logic fdx;
      logic stretch;
      logic mii_link;
      logic lpi;
      logic mii_err;
   } ptd_led_in_t;

   // control word to the analog and test logic
   typedef struct packed {
      logic       lower_thr;
      logic [3:0] squelch;
      logic       link_pulse_off;
      logic       jabber_off;
      logic [7:0] gap_len;
      logic [10:0] pkt_len;
      logic       diag_run;
      logic       rescal;
      logic [3:0] test10_pat;
      logic [4:0] test100_zeros;
      logic       test100_clear;
   } ptd_ctrl_t;

   // cable diagnostic state
   typedef enum logic [1:0] {
      CD_IDLE = 2'b00,
      CD_RUN  = 2'b01,
      CD_DONE = 2'b11
   } ptd_cd_t;

   // module state apart from the strap and blink registers
   typedef struct packed {
      logic [15:0] tbt;
      logic        pol;
      logic [7:0]  err_cnt;
      logic [7:0]  err_frz;
      logic [7:0]  gap;
      logic [15:0] bc2;
      logic        start;
      logic        rescal;
      logic        done;
      logic        fail;
      ptd_cd_t     cd;
      logic [15:0] mled;
      logic [15:0] comp;
      logic [15:0] d101;
      logic [15:0] d10a;
      logic [15:0] d123;
      logic [15:0] d130;
      logic [15:0] cds;
      logic [3:0]  rst_cnt;
      logic        lost;
      logic        prbs_hit;
      logic        link_q;
      logic        wrap_pulse;
      logic [15:0] rdata;
      logic        led;
   } ptd_state_t;
endpackage

// file: hw/ptd_regs.sv
// register bank for 10base-t tuning, self test, cable diag and led
`timescale 1ns/1ps
module ptd_regs (
   // clock and reset
   input  wire  logic              clk,
   input  wire  logic              rst_b,
   // management access
   input  wire  ptd_pkg::ptd_mgmt_t mgmt,
   output logic [15:0]             rdata,
   // datapath status
   input  wire  logic              inv_pol_evt,
   input  wire  logic              prbs_err,
   input  wire  logic              wrap_mode,
   input  wire  logic              mode_10te,
   input  wire  logic              diag_done,
   input  wire  logic              diag_fail,
   input  wire  logic              test10_en,
   input  wire  logic              test100_en,
   input  wire  logic              test100_ext,
   input  wire  ptd_pkg::ptd_led_in_t led_in,
   input  wire  logic              col_strap,
   // outputs
   output ptd_pkg::ptd_ctrl_t      ctrl,
   output logic                    main_phy_status_pol,
   output logic                    err_wrap_pulse,
   output logic                    device_reset_b,
   output logic                    circuit_restart,
   output logic                    first_led_pin
);
   import ptd_pkg::*;

   ptd_state_t s;        // current state
   ptd_state_t next_s;   // next state
   logic       strap_q1; // strap sync stage one
   logic       strap_q2; // strap sync stage two
   logic       strap_lat;  // latched strap
   logic       strap_done; // strap has been captured
   logic       soft_rst;   // soft hard reset request
   logic       blink;      // slow blink toggle
   logic [19:0] blink_cnt; // blink divider

   // multifunction led source decode
   function automatic logic led_src(input logic [3:0] sel, input ptd_led_in_t li,
                                    input logic lost, input logic prbs, input logic bl);
      case (sel)
         4'h0: led_src = li.link;
         4'h1: led_src = li.rxtx_act;
         4'h2: led_src = li.tx_act;
         4'h3: led_src = li.rx_act;
         4'h4: led_src = li.col;
         4'h5: led_src = li.spd100;
         4'h6: led_src = ~li.spd100;
         4'h7: led_src = li.fdx;
         4'h8: led_src = li.link & ~(li.rxtx_act & bl);
         4'h9: led_src = li.stretch;
         4'ha: led_src = li.mii_link;
         4'hb: led_src = li.lpi;
         4'hc: led_src = li.mii_err;
         4'hd: led_src = lost;
         4'he: led_src = prbs;
         default: led_src = 1'b0;
      endcase
   endfunction

   // strap synchroniser, then capture once after reset release
   always_ff @(posedge clk) begin
      strap_q1 <= col_strap;
      strap_q2 <= strap_q1;
      // soft hard reset re-captures the strap just as the pin does
      if (!rst_b || soft_rst) begin
         strap_done <= 1'b0;
         strap_lat  <= 1'b1;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         strap_lat  <= strap_q2;
      end
   end

   // blink divider
   always_ff @(posedge clk) begin
      if (!rst_b || soft_rst) begin
         blink_cnt <= 20'h00000;
         blink     <= 1'b0;
      end else begin
         blink_cnt <= blink_cnt + 20'h00001;
         if (blink_cnt == 20'hfffff) begin
            blink <= ~blink;
         end
      end
   end

   // next state logic
   always_comb begin
      logic [15:0] rd;
      logic        wr_tbt;
      logic        rd_tbt;
      rd     = 16'h0000;
      wr_tbt = mgmt.wr && mgmt.addr == A_TBT;
      rd_tbt = mgmt.rd && mgmt.addr == A_TBT;
      next_s = s;
      next_s.wrap_pulse = 1'b0;
      soft_rst = 1'b0;
      if (wr_tbt) begin
         next_s.tbt = mgmt.wdata & M_TBT;
      end
      if (mgmt.wr && mgmt.addr == A_BC2) begin
         next_s.bc2 = mgmt.wdata & M_BC2;
      end
      if (mgmt.wr && mgmt.addr == A_MLED) begin
         next_s.mled = mgmt.wdata & M_MLED;
      end
      if (mgmt.wr && mgmt.addr == A_COMP) begin
         next_s.comp = mgmt.wdata & M_COMP;
      end
      if (mgmt.wr && mgmt.addr == A_D101) begin
         next_s.d101 = mgmt.wdata & M_D101;
      end
      if (mgmt.wr && mgmt.addr == A_D10A) begin
         next_s.d10a = mgmt.wdata;
      end
      if (mgmt.wr && mgmt.addr == A_D123) begin
         next_s.d123 = mgmt.wdata & M_D123;
      end
      if (mgmt.wr && mgmt.addr == A_D130) begin
         next_s.d130 = mgmt.wdata & M_D130;
      end
      if (mgmt.wr && mgmt.addr == A_CDS) begin
         next_s.cds = mgmt.wdata & M_CDS;
      end
      // polarity cleared by control read, event wins
      if (rd_tbt) begin
         next_s.pol = 1'b0;
      end
      if (inv_pol_evt) begin
         next_s.pol = 1'b1;
      end
      if (prbs_err) begin
         if (s.err_cnt == CNT_MAX) begin
            if (wrap_mode) begin
               next_s.err_cnt    = 8'h00;
               next_s.wrap_pulse = 1'b1;
            end
         end else begin
            next_s.err_cnt = s.err_cnt + 8'h01;
         end
         next_s.prbs_hit = 1'b1;
      end
      if (mgmt.wr && mgmt.addr == A_BC1) begin
         next_s.gap = mgmt.wdata[7:0];
         if (mgmt.wdata[B_FRZ]) begin
            next_s.err_frz  = s.err_cnt;
            next_s.err_cnt  = 8'h00;
            next_s.prbs_hit = 1'b0;
         end
      end
      if (mgmt.wr && mgmt.addr == A_CDC) begin
         next_s.rescal = mgmt.wdata[B_RESCAL];
         if (mgmt.wdata[B_START] && s.cd != CD_RUN) begin
            next_s.start = 1'b1;
            next_s.done  = 1'b0;
            next_s.fail  = 1'b0;
            next_s.cd    = CD_RUN;
         end
      end
      case (s.cd)
         CD_IDLE: begin
            next_s.cd = next_s.cd;
         end
         CD_RUN: begin
            if (diag_done) begin
               next_s.done  = 1'b1;
               next_s.fail  = diag_fail;
               next_s.start = 1'b0;
               next_s.cd    = CD_DONE;
            end
         end
         CD_DONE: begin
            next_s.cd = next_s.cd;
         end
         default: begin
            next_s.cd = CD_IDLE;
         end
      endcase
      if (s.rst_cnt != 4'h0) begin
         next_s.rst_cnt = s.rst_cnt - 4'h1;
      end
      if (mgmt.wr && mgmt.addr == A_RST) begin
         soft_rst = mgmt.wdata[B_HRST];
         if (mgmt.wdata[B_DRST]) begin
            next_s.rst_cnt = RESTART_CYC;
         end
      end
      // link lost held until status read
      next_s.link_q = led_in.link;
      if (mgmt.rd && mgmt.addr == A_BSTAT) begin
         next_s.lost = 1'b0;
      end
      if (s.link_q && !led_in.link) begin
         next_s.lost = 1'b1;
      end
      // read mux
      case (mgmt.addr)
         A_TBT:  rd = s.tbt | (16'(s.pol) << B_POL);
         A_BC1:  rd = {s.err_frz, s.gap};
         A_BC2:  rd = s.bc2;
         A_CDC:  rd = {s.start, s.rescal, 12'h000, s.done, s.fail};
         A_RST:  rd = 16'h0000;
         A_MLED: rd = s.mled;
         A_COMP: rd = s.comp;
         A_D101: rd = s.d101;
         A_D10A: rd = s.d10a;
         A_D123: rd = s.d123;
         A_D130: rd = s.d130;
         A_CDS:  rd = s.cds;
         default: rd = 16'h0000;
      endcase
      if (mgmt.rd) begin
         next_s.rdata = rd;
      end
      if (s.mled[B_ROUTE]) begin
         next_s.led = led_src(s.mled[B_SRCH:B_SRCL], led_in, s.lost, s.prbs_hit, blink);
      end else begin
         next_s.led = led_in.link;
      end
   end

   // state register; soft hard reset acts like the pin
   always_ff @(posedge clk) begin
      if (!rst_b || soft_rst) begin
         s      <= '0;
         s.gap  <= R_GAP;
         s.bc2  <= R_BC2;
         s.mled <= R_MLED;
         s.d101 <= R_D101;
         s.d10a <= R_D10A;
         s.d123 <= R_D123;
         s.d130 <= R_D130;
         s.cds  <= R_CDS;
         s.cd   <= CD_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // outputs
   always_comb begin
      ctrl = '0;
      ctrl.lower_thr      = s.tbt[B_THR];
      ctrl.squelch        = s.tbt[B_SQH:B_SQL];
      ctrl.link_pulse_off = s.tbt[B_NLP];
      ctrl.jabber_off     = s.tbt[B_JAB] & mode_10te;
      ctrl.gap_len        = s.gap;
      ctrl.pkt_len        = s.bc2[10:0];
      ctrl.diag_run       = s.start;
      ctrl.rescal         = s.rescal;
      ctrl.test10_pat     = test10_en ? s.comp[3:0] : 4'h0;
      ctrl.test100_zeros  = test100_en ? {test100_ext, s.comp[3:0]} : 5'h00;
      ctrl.test100_clear  = test100_en && {test100_ext, s.comp[3:0]} == 5'h00;
   end

   assign rdata               = s.rdata;
   assign main_phy_status_pol = s.pol;
   assign err_wrap_pulse      = s.wrap_pulse;
   assign device_reset_b      = rst_b & ~soft_rst;
   assign circuit_restart     = s.rst_cnt != 4'h0;
   // strap polarity with swap; pull-up means active low
   assign first_led_pin = s.led ^ strap_lat ^ s.mled[B_SWAP];
endmodule

// file: bench/ptd_regs_properties.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
module ptd_regs_props (
   // clock and reset
   input wire logic               clk,
   input wire logic               rst_b,
   // management access
   input wire ptd_pkg::ptd_mgmt_t mgmt,
   input wire logic [15:0]        rdata,
   // datapath status
   input wire logic               inv_pol_evt,
   input wire logic               prbs_err,
   input wire logic               wrap_mode,
   input wire logic               mode_10te,
   input wire logic               diag_done,
   // watched outputs
   input wire ptd_pkg::ptd_ctrl_t ctrl,
   input wire logic               main_phy_status_pol,
   input wire logic               err_wrap_pulse,
   input wire logic               device_reset_b,
   input wire logic               circuit_restart
);
   import ptd_pkg::*;
   // one clock domain, sync reset
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_POL_SET: assert property (
      inv_pol_evt |=> main_phy_status_pol)
      else $error("polarity flag not set by event");
   AST_POL_CLR: assert property (
      mgmt.rd && mgmt.addr == A_TBT && !inv_pol_evt |=> !main_phy_status_pol)
      else $error("polarity flag kept after control read");
   AST_POL_KEEP: assert property (
      main_phy_status_pol && mgmt.rd && mgmt.addr == A_PSTS |=> main_phy_status_pol)
      else $error("polarity flag lost on status read");
   AST_THR_SRC: assert property (
      $rose(ctrl.lower_thr) |-> $past(mgmt.wr && mgmt.addr == A_TBT))
      else $error("threshold changed without a write");
   AST_JAB_TE: assert property (
      !mode_10te |-> !ctrl.jabber_off)
      else $error("jabber disable active outside 10te");
   AST_START_GO: assert property (
      mgmt.wr && mgmt.addr == A_CDC && mgmt.wdata[15] && !ctrl.diag_run
      |=> ctrl.diag_run)
      else $error("diagnostic not launched");
   AST_START_CLR: assert property (
      ctrl.diag_run && diag_done |=> !ctrl.diag_run)
      else $error("start bit not cleared on done");
   AST_HRST: assert property (
      mgmt.wr && mgmt.addr == A_RST && mgmt.wdata[15] |-> !device_reset_b)
      else $error("soft hard reset not applied");
   AST_RESTART: assert property (
      mgmt.wr && mgmt.addr == A_RST && mgmt.wdata[14] && !mgmt.wdata[15]
      |=> circuit_restart [*8] ##1 !circuit_restart)
      else $error("restart pulse length wrong");
   AST_WRAP: assert property (
      err_wrap_pulse |-> $past(wrap_mode && prbs_err) ##1 !err_wrap_pulse)
      else $error("wrap pulse without continuous mode error");
   AST_UNMAP: assert property (
      mgmt.rd && mgmt.addr == 9'h1ff |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
endmodule

// file: bench/ptd_sta.sv
// station management controller model issuing register accesses
`timescale 1ns/1ps
module ptd_sta (
   // clock
   input  wire logic         clk,
   // management bus
   output ptd_pkg::ptd_mgmt_t mgmt,
   input  wire logic [15:0]  rdata
);
   import ptd_pkg::*;
   // bus idle from time zero
   initial mgmt = '0;
   // write: held one cycle, then strobe drops and stale fields are scrambled
   task wr(input logic [8:0] a, input logic [15:0] d);
      @(posedge clk);
      mgmt <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clk);
      mgmt <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // read: data is taken one edge after the request edge
   task rd(input logic [8:0] a, output logic [15:0] d);
      @(posedge clk);
      mgmt <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
      @(posedge clk);
      mgmt <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'hffff};
      @(posedge clk);
      d = rdata;
   endtask
endmodule

// file: bench/testbench.sv
// self-checking bench for the test, diagnostic and led register bank
`timescale 1ns/1ps
module testbench;
   import ptd_pkg::*;
   // design signals
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   ptd_mgmt_t   mgmt;
   logic [15:0] rdata;
   logic [15:0] rv;
   logic        inv_pol_evt, prbs_err, wrap_mode, mode_10te, diag_done, diag_fail;
   logic        test10_en, test100_en, test100_ext, col_strap;
   ptd_led_in_t led_in;
   ptd_ctrl_t   ctrl;
   logic        main_phy_status_pol, err_wrap_pulse, device_reset_b;
   logic        circuit_restart, first_led_pin;
   int          bad_count = 0;
   int          tests_run = 0;
   int          wraps = 0;
   // register table: address, reset value, readback after all-ones write
   logic [8:0]  adr [12] = '{A_TBT, A_BC1, A_BC2, A_CDC, A_RST, A_MLED, A_COMP,
                             A_D101, A_D10A, A_D123, A_D130, A_CDS};
   logic [15:0] rst_v [12] = '{16'h0000, 16'h007d, 16'h05ee, 16'h0000, 16'h0000, 16'h0041,
                             16'h0000, 16'h2082, 16'h2040, 16'h051c, 16'h4f28, 16'h0c12};
   logic [15:0] one_v [12] = '{16'h3e81, 16'h00ff, 16'h07ff, 16'h0000, 16'h0000, 16'h0279,
                             16'h000f, 16'hff9f, 16'hffff, 16'h7fff, 16'h7fff, 16'h7770};

   always #12.5 clk = ~clk;

   ptd_regs ptd_regs_inst (.clk, .rst_b, .mgmt, .rdata, .inv_pol_evt, .prbs_err, .wrap_mode,
      .mode_10te, .diag_done, .diag_fail, .test10_en, .test100_en, .test100_ext, .led_in,
      .col_strap, .ctrl, .main_phy_status_pol, .err_wrap_pulse, .device_reset_b,
      .circuit_restart, .first_led_pin);
   ptd_sta ptd_sta_inst (.clk, .mgmt, .rdata);

   // count wrap pulses seen
   always @(posedge clk) begin
      if (err_wrap_pulse === 1'b1) begin
         wraps <= wraps + 1;
      end
   end

   task chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task rchk(input logic [8:0] a, input logic [15:0] e);
      ptd_sta_inst.rd(a, rv);
      chk(rv, e);
   endtask

   // watchdog against a hung sequence
   initial begin
      tick(20000);
      bad_count++;
      results();
   end

   initial begin
      {inv_pol_evt, prbs_err, wrap_mode, diag_done, diag_fail} = 5'h00;
      {test10_en, test100_en, test100_ext, col_strap} = 4'h0;
      mode_10te = 1'b1;
      led_in = '0;
      tick(16);
      rst_b <= 1'b1;
      tick(3);
      // reset values, then writable bits only
      for (int i = 0; i < 12; i++) begin
         rchk(adr[i], rst_v[i]);
      end
      rchk(9'h1ff, 16'h0000);
      for (int i = 0; i < 12; i++) begin
         if (i != 3 && i != 4) begin
            ptd_sta_inst.wr(adr[i], 16'hffff);
            rchk(adr[i], one_v[i]);
         end
      end
      chk({9'h000, ctrl.lower_thr, ctrl.squelch, ctrl.link_pulse_off, ctrl.jabber_off},
          16'h007f);
      chk({5'h00, ctrl.pkt_len}, 16'h07ff);
      chk({8'h00, ctrl.gap_len}, 16'h00ff);
      mode_10te <= 1'b0;
      ptd_sta_inst.wr(A_TBT, 16'h1000);
      tick(1);
      chk({10'h000, ctrl.lower_thr, ctrl.squelch, ctrl.jabber_off}, 16'h0010);
      // polarity copy: status read keeps it, control read clears it
      inv_pol_evt <= 1'b1;
      tick(1);
      inv_pol_evt <= 1'b0;
      ptd_sta_inst.rd(A_PSTS, rv);
      chk({15'h0000, main_phy_status_pol}, 16'h0001);
      rchk(A_TBT, 16'h1010);
      rchk(A_TBT, 16'h1000);
      // single mode: frozen count, saturation
      prbs_err <= 1'b1;
      tick(5);
      prbs_err <= 1'b0;
      ptd_sta_inst.wr(A_BC1, 16'h807d);
      rchk(A_BC1, 16'h057d);
      prbs_err <= 1'b1;
      tick(300);
      prbs_err <= 1'b0;
      rchk(A_BC1, 16'h057d);
      ptd_sta_inst.wr(A_BC1, 16'h807d);
      rchk(A_BC1, 16'hff7d);
      chk(wraps[15:0], 16'h0000);
      // continuous mode wraps once over 300 errors
      wrap_mode <= 1'b1;
      ptd_sta_inst.wr(A_BC1, 16'h8000);
      prbs_err <= 1'b1;
      tick(300);
      prbs_err <= 1'b0;
      tick(2);
      chk(wraps[15:0], 16'h0001);
      // cable diagnostic with failure
      ptd_sta_inst.wr(A_CDC, 16'hc000);
      tick(1);
      chk({14'h0000, ctrl.rescal, ctrl.diag_run}, 16'h0003);
      {diag_done, diag_fail} <= 2'b11;
      tick(1);
      {diag_done, diag_fail} <= 2'b00;
      rchk(A_CDC, 16'h4003);
      // soft hard reset restores table values
      ptd_sta_inst.wr(A_MLED, 16'h0000);
      ptd_sta_inst.wr(A_RST, 16'h8000);
      tick(4);
      rchk(A_MLED, 16'h0041);
      rchk(A_RST, 16'h0000);
      // restart keeps registers
      ptd_sta_inst.wr(A_BC2, 16'h0123);
      ptd_sta_inst.wr(A_RST, 16'h4000);
      tick(1);
      chk({15'h0000, circuit_restart}, 16'h0001);
      tick(9);
      chk({15'h0000, circuit_restart}, 16'h0000);
      rchk(A_BC2, 16'h0123);
      rchk(A_RST, 16'h0000);
      // led with pull-down strap: active high, swap inverts
      led_in.link <= 1'b1;
      ptd_sta_inst.wr(A_MLED, 16'h0001);
      tick(3);
      chk({15'h0000, first_led_pin}, 16'h0001);
      ptd_sta_inst.wr(A_MLED, 16'h0201);
      tick(3);
      chk({15'h0000, first_led_pin}, 16'h0000);
      ptd_sta_inst.wr(A_MLED, 16'h0000);
      tick(3);
      chk({15'h0000, first_led_pin}, 16'h0001);
      ptd_sta_inst.wr(A_MLED, 16'h0069);
      led_in.link <= 1'b0;
      tick(3);
      chk({15'h0000, first_led_pin}, 16'h0001);
      ptd_sta_inst.rd(A_BSTAT, rv);
      tick(3);
      chk({15'h0000, first_led_pin}, 16'h0000);
      // every 10base-t pattern code
      test10_en <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         ptd_sta_inst.wr(A_COMP, 16'(c));
         tick(1);
         chk({12'h000, ctrl.test10_pat}, 16'(c));
      end
      // 100base-tx zero count with the extension bit, then the clear flag at zero count
      test10_en <= 1'b0;
      test100_ext <= 1'b1;
      ptd_sta_inst.wr(A_COMP, 16'h0003);
      test100_en <= 1'b0;
      tick(1);
      test100_en <= 1'b1;
      tick(2);
      chk({11'h000, ctrl.test100_zeros}, 16'h0013);
      test100_ext <= 1'b0;
      ptd_sta_inst.wr(A_COMP, 16'h0000);
      tick(1);
      chk({15'h0000, ctrl.test100_clear}, 16'h0001);
      results();
   end
endmodule

bind ptd_regs ptd_regs_props ptd_regs_props_inst (.clk, .rst_b, .mgmt, .rdata, .inv_pol_evt,
   .prbs_err, .wrap_mode, .mode_10te, .diag_done, .ctrl, .main_phy_status_pol,
   .err_wrap_pulse, .device_reset_b, .circuit_restart);
